// [incr_or_move_pkg.sv]
// constants and types for the increment/or/move execution block
package incr_or_move_pkg;
  localparam int DATA_WIDTH = 8;
  localparam int ADDR_WIDTH = 7;
  localparam int FILE_DEPTH = 128;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic Z_RESET = 1'b0;
  localparam logic DEST_ACCUM = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam logic [2:0] SKIP_CYCLES = 3'h2;
  typedef enum logic [2:0] {
    no_operation = 3'b000,
    increment_register = 3'b001,
    increment_skip_if_zero = 3'b010,
    or_literal_into_accumulator = 3'b011,
    or_accumulator_with_register = 3'b100,
    move_register = 3'b101
  } opcode_type;
  typedef enum logic [0:0] {
    st_run = 1'b0,
    st_skip = 1'b1
  } state_type;
endpackage : incr_or_move_pkg

// [incr_or_move_exec.sv]
// execution unit for increment, inclusive or and move file instructions
// Notes on behaviour
// - a 7-bit address picks the file register and dest bit 1 writes back to it, 0 writes to the accumulator.
// - increment-skip adds one and on a zero result replaces the next instruction with a no-op, flags untouched.
// - increment-skip with a nonzero result lets the next instruction run normally.
// - plain increment adds one, stores to the chosen destination, updates zero and never skips.
// - or-literal ors the accumulator with the 8-bit immediate into the accumulator and updates zero.
// - or-register ors the accumulator with the file register into the chosen destination and updates zero.
// - move copies the file register to the chosen destination, updates zero, in one cycle.
// - move with dest bit 1 rewrites the register yet still updates zero so it can test it.
`timescale 1ns/1ps
module incr_or_move_exec #(
  parameter int DATA_WIDTH = incr_or_move_pkg::DATA_WIDTH,
  parameter int ADDR_WIDTH = incr_or_move_pkg::ADDR_WIDTH
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire incr_or_move_pkg::opcode_type instr_op,
  input wire logic [ADDR_WIDTH-1:0] instr_addr,
  input wire logic instr_dest,
  input wire logic [DATA_WIDTH-1:0] instr_literal,
  output logic [DATA_WIDTH-1:0] accum_reg,
  output logic zero_reg,
  output logic skip_reg,
  output logic done_reg,
  output logic [DATA_WIDTH-1:0] result_reg
);
  localparam int DEPTH = 1 << ADDR_WIDTH;

  logic [DATA_WIDTH-1:0] file_mem [DEPTH];
  incr_or_move_pkg::state_type state_reg;
  incr_or_move_pkg::state_type state_next;

  // operand fetch and decode
  wire run_now = instr_valid && (state_reg == incr_or_move_pkg::st_run);
  wire [DATA_WIDTH-1:0] file_val = file_mem[instr_addr];
  wire [DATA_WIDTH-1:0] inc_val = file_val + DATA_WIDTH'(incr_or_move_pkg::ONE_BYTE);
  wire [DATA_WIDTH-1:0] or_lit = accum_reg | instr_literal;
  wire [DATA_WIDTH-1:0] or_reg = accum_reg | file_val;
  // opcode decode
  wire is_inc = instr_op == incr_or_move_pkg::increment_register;
  wire is_incsz = instr_op == incr_or_move_pkg::increment_skip_if_zero;
  wire is_orl = instr_op == incr_or_move_pkg::or_literal_into_accumulator;
  wire is_orf = instr_op == incr_or_move_pkg::or_accumulator_with_register;
  wire is_mov = instr_op == incr_or_move_pkg::move_register;
  wire is_file_op = is_inc | is_incsz | is_orf | is_mov;
  wire [DATA_WIDTH-1:0] result_val = (is_inc | is_incsz) ? inc_val :
                                     is_orl ? or_lit :
                                     is_orf ? or_reg :
                                     is_mov ? file_val : accum_reg;
  wire to_file = run_now && is_file_op && (instr_dest == incr_or_move_pkg::DEST_FILE);
  wire to_accum = run_now && ((is_file_op && (instr_dest == incr_or_move_pkg::DEST_ACCUM)) || is_orl);
  // zero flag from result, not for skip form
  wire z_update = run_now && (is_inc | is_orl | is_orf | is_mov);
  wire result_zero = result_val == DATA_WIDTH'(incr_or_move_pkg::ZERO_BYTE);
  // skip only on zero increment-skip result
  wire take_skip = run_now && is_incsz && result_zero;

  // sequencer: skip state swallows the next slot as a no-op
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      incr_or_move_pkg::st_run: begin
        if (take_skip) begin
          state_next = incr_or_move_pkg::st_skip;
        end
      end
      incr_or_move_pkg::st_skip: begin
        if (instr_valid) begin
          state_next = incr_or_move_pkg::st_run;
        end
      end
      default: state_next = incr_or_move_pkg::st_run;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg <= incr_or_move_pkg::st_run;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (to_file) begin
      file_mem[instr_addr] <= result_val;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      accum_reg <= DATA_WIDTH'(incr_or_move_pkg::W_RESET);
      zero_reg <= incr_or_move_pkg::Z_RESET;
    end else begin
      if (to_accum) begin
        accum_reg <= result_val;
      end
      if (z_update) begin
        zero_reg <= result_zero;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      skip_reg <= 1'b0;
      done_reg <= 1'b0;
      result_reg <= DATA_WIDTH'(incr_or_move_pkg::ZERO_BYTE);
    end else begin
      skip_reg <= instr_valid && (state_reg == incr_or_move_pkg::st_skip);
      done_reg <= run_now;
      if (run_now) begin
        result_reg <= result_val;
      end
    end
  end

  zero_flag_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    z_update |=> zero_reg == (result_reg == '0)) else $error("zero flag wrong");
  skip_flags_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (run_now && is_incsz) |=> $stable(zero_reg)) else $error("skip form changed zero");
  skip_next_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    take_skip ##1 instr_valid |=> skip_reg && !done_reg) else $error("next not skipped");
  no_skip_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (run_now && is_incsz && !result_zero) ##1 instr_valid |=> done_reg) else $error("bad skip");
  inc_noskip_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (run_now && is_inc) |=> state_reg == incr_or_move_pkg::st_run) else $error("increment skipped");
  or_lit_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (run_now && is_orl) |=> accum_reg == ($past(accum_reg) | $past(instr_literal))) else $error("or literal bad");
  or_reg_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (run_now && is_orf && !instr_dest) |=> accum_reg == $past(or_reg)) else $error("or register bad");
  // move to accumulator in one cycle
  move_w_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (run_now && is_mov && !instr_dest) |=> accum_reg == $past(file_val) && done_reg) else $error("move bad");
  move_f_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (run_now && is_mov && instr_dest) |=> $stable(accum_reg) && zero_reg == (result_reg == '0))
    else $error("move test bad");
  inc_file_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (run_now && is_inc && instr_dest) |=> $stable(accum_reg) && result_reg == $past(inc_val))
    else $error("increment dest bad");

  inc_step_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (run_now && is_inc)
    |=> (result_reg - $past(file_val)) == DATA_WIDTH'(1))
    else $error("increment step wrong");
  inc_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (run_now && is_inc)
    |=> zero_reg == ($past(file_val) == '1) && !skip_reg)
    else $error("increment zero wrong");
  skip_accum_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (run_now && is_incsz && !instr_dest)
    |=> (accum_reg - $past(file_val)) == DATA_WIDTH'(1))
    else $error("skip form accumulator wrong");
  // file write seen by next slot
  file_wb_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (run_now && is_file_op && instr_dest) ##1 (run_now && instr_addr == $past(instr_addr))
    |-> file_val == $past(result_val))
    else $error("file write-back lost");
  or_file_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (run_now && is_orf && instr_dest)
    |=> $stable(accum_reg) && result_reg == ($past(accum_reg) | $past(file_val)))
    else $error("or register to file bad");
  or_lit_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (run_now && is_orl)
    |=> zero_reg == (($past(accum_reg) | $past(instr_literal)) == '0))
    else $error("or literal zero bad");
  // move flags zero in one cycle
  move_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (run_now && is_mov)
    |=> zero_reg == ($past(file_val) == '0) && done_reg)
    else $error("move zero bad");
  swallow_keeps_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (instr_valid && state_reg == incr_or_move_pkg::st_skip)
    |=> $stable(accum_reg) && $stable(zero_reg) && $stable(result_reg) && skip_reg)
    else $error("swallowed slot acted");
  // idle cycles keep the skip pending
  skip_wait_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_reg == incr_or_move_pkg::st_skip && !instr_valid)
    |=> state_reg == incr_or_move_pkg::st_skip && !skip_reg && !done_reg)
    else $error("skip lost on idle");
  // each slot executes or is swallowed
  one_outcome_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    instr_valid
    |=> done_reg != skip_reg)
    else $error("slot outcome wrong");

  // main scenarios reached
  skip_taken_c: cover property (@(posedge sys_clk) disable iff (!reset_n) take_skip ##1 instr_valid);
  move_test_c: cover property (@(posedge sys_clk) disable iff (!reset_n) run_now && is_mov && instr_dest);
  or_zero_c: cover property (@(posedge sys_clk) disable iff (!reset_n) z_update && result_zero);
  // nonzero skip result runs the next slot
  skip_nonzero_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
    (run_now && is_incsz && !result_zero) ##1 instr_valid);
  // skip held over an idle cycle
  skip_idle_c: cover property (@(posedge sys_clk) disable iff (!reset_n)
    state_reg == incr_or_move_pkg::st_skip && !instr_valid);
endmodule : incr_or_move_exec

// [incr_or_move_exec_bench.sv]
// self-checking bench for the increment/or/move execution unit
`timescale 1ns/1ps
module incr_or_move_exec_bench;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic instr_valid = 1'b0;
  incr_or_move_pkg::opcode_type instr_op = incr_or_move_pkg::no_operation;
  logic [6:0] instr_addr = 7'h00;
  logic instr_dest = 1'b0;
  logic [7:0] instr_literal = 8'h00;
  logic [7:0] accum_reg, result_reg, w_exp, r_exp;
  logic zero_reg, skip_reg, done_reg, z_exp, skip_exp, done_exp, in_skip, r_chk;
  logic [7:0] mem [128];
  logic [31:0] r;
  int err_total = 0;
  int n_checks = 0;
  int seed = 70466;
  initial forever #4 sys_clk = ~sys_clk;
  incr_or_move_exec #(.DATA_WIDTH(8), .ADDR_WIDTH(7)) incr_or_move_exec_inst (.sys_clk(sys_clk),
    .reset_n(reset_n), .instr_valid(instr_valid), .instr_op(instr_op), .instr_addr(instr_addr),
    .instr_dest(instr_dest), .instr_literal(instr_literal), .accum_reg(accum_reg), .zero_reg(zero_reg),
    .skip_reg(skip_reg), .done_reg(done_reg), .result_reg(result_reg));
  // expected 8-bit result of one executed op
  function automatic logic [7:0] calc(input logic [2:0] op, input logic [7:0] f, input logic [7:0] w,
    input logic [7:0] k);
    case (op)
      3'h1, 3'h2: return f + 8'h01;
      3'h3: return w | k;
      3'h4: return w | f;
      default: return f;
    endcase
  endfunction : calc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // hold reset n edges and restart the expected state
  task automatic rst(input int n);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    instr_valid <= 1'b0;
    repeat (n) @(posedge sys_clk);
    reset_n <= 1'b1;
    {w_exp, r_exp, z_exp, skip_exp, done_exp, in_skip, r_chk} = {16'h0000, 5'h01};
  endtask : rst
  // drive one slot, check the previous one, then predict this one
  task automatic slot(input logic v, input logic [2:0] op, input logic [6:0] a, input logic d, input logic [7:0] k);
    logic [7:0] res;
    @(posedge sys_clk);
    instr_valid <= v;
    instr_op <= incr_or_move_pkg::opcode_type'(op);
    instr_addr <= a;
    instr_dest <= d;
    instr_literal <= k;
    #1;
    chk({7'h00, done_reg}, {7'h00, done_exp}, "done");
    chk({7'h00, skip_reg}, {7'h00, skip_exp}, "skip");
    chk(accum_reg, w_exp, "accum");
    chk({7'h00, zero_reg}, {7'h00, z_exp}, "zero");
    if (r_chk) chk(result_reg, r_exp, "result");
    {done_exp, skip_exp} = 2'h0;
    if (v && in_skip) {skip_exp, in_skip} = 2'h2;
    else if (v) begin
      done_exp = 1'b1;
      r_chk = op != 3'h0 && op < 3'h6;
      if (r_chk) begin
        res = calc(op, mem[a], w_exp, k);
        r_exp = res;
        if (op == 3'h3 || !d) w_exp = res;
        else mem[a] = res;
        if (op != 3'h2) z_exp = res == 8'h00;
        else in_skip = res == 8'h00;
      end
    end
  endtask : slot
  initial begin
    rst(4);
    // fill every file register with ff through the or path
    slot(1'b1, 3'h3, 7'h00, 1'b0, 8'hff);
    for (int i = 0; i < 128; i++) slot(1'b1, 3'h4, i[6:0], 1'b1, 8'h00);
    // zero skip across an idle cycle, then nonzero skip result
    slot(1'b1, 3'h2, 7'h05, 1'b1, 8'h00);
    slot(1'b0, 3'h1, 7'h05, 1'b1, 8'h00);
    slot(1'b1, 3'h1, 7'h05, 1'b1, 8'h00);
    slot(1'b1, 3'h2, 7'h05, 1'b0, 8'h00);
    slot(1'b1, 3'h5, 7'h05, 1'b1, 8'h00);
    // reset while a skip is pending
    slot(1'b1, 3'h2, 7'h06, 1'b1, 8'h00);
    rst(1);
    slot(1'b1, 3'h1, 7'h06, 1'b0, 8'h00);
    repeat (3000) begin
      r = $random(seed);
      slot(r[31] | r[30], r[2:0], r[9:3], r[10], r[18:11]);
    end
    slot(1'b0, 3'h0, 7'h00, 1'b0, 8'h00);
    end_of_test();
  end
endmodule : incr_or_move_exec_bench
